/* logic/uem_aer_mask.v */
// What this block does
// - Mask register at 0x108, resets zero, sticky
// - Masked error: no logging, no report
// - Bit 4 masks link protocol errors
// - Bit 5 masks surprise down errors
// - Bit 12 masks poisoned packets
// - Bit 13 masks flow control errors
// - Bit 16 masks unexpected completions
// - Bit 17 masks receiver overflow
// - Bit 18 masks malformed packets
// - Bit 19 masks end-to-end CRC errors
// - Bit 20 masks unsupported requests
// - Bits 14 and 15 read zero
// - Bit 0 stored, no effect
// - Status bits set by hardware, write-one-clears
`timescale 1ns/1ps
`default_nettype none
`include "uem_defs.vh"
module uem_aer_mask (
  input wire i_clk,
  input wire i_resetn,
  input wire i_cfg_wr,
  input wire i_cfg_rd,
  input wire [11:0] i_cfg_addr,
  input wire [3:0] i_cfg_be,
  input wire [31:0] i_cfg_wdata,
  input wire [31:0] i_err_detect,
  output reg [31:0] o_cfg_rdata_ff,
  output reg o_cfg_rd_valid_ff,
  output reg [31:0] o_uncorrectable_error_mask_ff,
  output reg [31:0] o_uncorrectable_error_status_ff,
  output reg [31:0] o_err_report_ff,
  output reg o_err_report_valid_ff
);
  wire [31:0] mask_q;
  wire [31:0] status_q;
  wire wr_mask;
  wire wr_status;
  wire [31:0] unmasked;
  reg [31:0] nxt_cfg_rdata_ff;

  function is_addr;
    input [11:0] a;
    input [11:0] off;
    begin
      is_addr = (a[11:2] == off[11:2]);
    end
  endfunction

  assign wr_mask = i_cfg_wr & is_addr(i_cfg_addr, `UEM_OFF_MASK);
  assign wr_status = i_cfg_wr & is_addr(i_cfg_addr, `UEM_OFF_STATUS);

  // Bit 0 is stored but kept out of the class set, so it never gates anything
  assign unmasked = i_err_detect & `UEM_CLASS_MASK & ~mask_q;

  // Reserved and hardwired bits are dropped by WR_BITS
  uem_sticky_reg #(
    .WR_BITS(`UEM_WR_MASK),
    .W1C(1'b0)
  ) u_mask (
    .i_clk(i_clk),
    .i_sticky_resetn(i_resetn),
    .i_wr(wr_mask),
    .i_be(i_cfg_be),
    .i_wdata(i_cfg_wdata),
    .i_set(32'h00000000),
    .o_q_ff(mask_q)
  );

  // Masked events never reach the status log
  uem_sticky_reg #(
    .WR_BITS(`UEM_CLASS_MASK),
    .W1C(1'b1)
  ) u_status (
    .i_clk(i_clk),
    .i_sticky_resetn(i_resetn),
    .i_wr(wr_status),
    .i_be(i_cfg_be),
    .i_wdata(i_cfg_wdata),
    .i_set(unmasked),
    .o_q_ff(status_q)
  );

  always @* begin
    nxt_cfg_rdata_ff = 32'h00000000;
    if (is_addr(i_cfg_addr, `UEM_OFF_MASK)) begin
      nxt_cfg_rdata_ff = mask_q & `UEM_WR_MASK;
    end else if (is_addr(i_cfg_addr, `UEM_OFF_STATUS)) begin
      nxt_cfg_rdata_ff = status_q;
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cfg_rdata_ff <= 32'h00000000;
      o_cfg_rd_valid_ff <= 1'b0;
      o_uncorrectable_error_mask_ff <= `UEM_RESET_VAL;
      o_uncorrectable_error_status_ff <= `UEM_RESET_VAL;
      o_err_report_ff <= 32'h00000000;
      o_err_report_valid_ff <= 1'b0;
    end else begin
      o_cfg_rd_valid_ff <= i_cfg_rd;
      o_cfg_rdata_ff <= i_cfg_rd ? nxt_cfg_rdata_ff : 32'h00000000;
      o_uncorrectable_error_mask_ff <= mask_q;
      o_uncorrectable_error_status_ff <= status_q;
      o_err_report_ff <= unmasked;
      o_err_report_valid_ff <= |unmasked;
    end
  end
endmodule // uem_aer_mask
`default_nettype wire

/* logic/uem_defs.vh */
`ifndef UEM_DEFS_VH
`define UEM_DEFS_VH

// Configuration space offsets (byte addresses)
`define UEM_OFF_STATUS 12'h104
`define UEM_OFF_MASK 12'h108

// Error class bit positions
`define UEM_BIT_LEGACY 0
`define UEM_BIT_LINK_PROTO 4
`define UEM_BIT_SURPRISE_DOWN 5
`define UEM_BIT_POISONED 12
`define UEM_BIT_FC_PROTO 13
`define UEM_BIT_CPL_TIMEOUT 14
`define UEM_BIT_CPL_ABORT 15
`define UEM_BIT_UNEXP_CPL 16
`define UEM_BIT_RX_OVERFLOW 17
`define UEM_BIT_MALFORMED 18
`define UEM_BIT_ECRC 19
`define UEM_BIT_UNSUP_REQ 20

// Writable bits of the mask register; status uses the class bits
`define UEM_WR_MASK 32'h001f3031
// Bits that name a real error class
`define UEM_CLASS_MASK 32'h001f3030
`define UEM_RESET_VAL 32'h00000000

`endif

/* logic/uem_sticky_reg.v */
`timescale 1ns/1ps
`default_nettype none
`include "uem_defs.vh"
// One 32-bit sticky register: software write or write-one-to-clear,
// with hardware set that wins over a clear in the same cycle.
module uem_sticky_reg #(
  parameter [31:0] WR_BITS = 32'h00000000,
  parameter W1C = 1'b0
) (
  input wire i_clk,
  input wire i_sticky_resetn,
  input wire i_wr,
  input wire [3:0] i_be,
  input wire [31:0] i_wdata,
  input wire [31:0] i_set,
  output reg [31:0] o_q_ff
);
  reg [31:0] lane;
  reg [31:0] nxt_q_ff;
  integer k;

  always @* begin
    lane = 32'h00000000;
    for (k = 0; k < 4; k = k + 1) begin
      lane[k*8 +: 8] = {8{i_be[k]}};
    end
    nxt_q_ff = o_q_ff;
    if (i_wr) begin
      if (W1C) begin
        nxt_q_ff = o_q_ff & ~(i_wdata & lane);
      end else begin
        nxt_q_ff = (o_q_ff & ~lane) | (i_wdata & lane);
      end
    end
    // Set beats clear
    nxt_q_ff = (nxt_q_ff | i_set) & WR_BITS;
  end

  always @(posedge i_clk or negedge i_sticky_resetn) begin
    if (!i_sticky_resetn) begin
      o_q_ff <= `UEM_RESET_VAL;
    end else begin
      o_q_ff <= nxt_q_ff;
    end
  end
endmodule // uem_sticky_reg
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk = 0, i_resetn = 0, i_cfg_wr = 0, i_cfg_rd = 0, o_cfg_rd_valid_ff, o_err_report_valid_ff;
  logic [3:0] i_cfg_be = 4'hf;
  logic [11:0] i_cfg_addr = 0;
  logic [31:0] i_cfg_wdata = 0, i_err_detect = 0, o_cfg_rdata_ff, o_err_report_ff, m, s, d, q[$];
  logic [31:0] o_uncorrectable_error_mask_ff, o_uncorrectable_error_status_ff;
  logic [7:0] cnt, n = 0;
  int failures = 0, checks = 0;
  always #25 i_clk = ~i_clk;
  uem_aer_mask i_dut (.*);
  uem_root i_root (.i_clk, .i_valid(o_err_report_valid_ff), .o_count_ff(cnt));
  // Reads and reports never share a cycle, so one queue serves both
  always @(posedge i_clk) begin
    #2;
    if (o_cfg_rd_valid_ff || o_err_report_valid_ff) begin
      checks++;
      if (q.size() == 0 || q.pop_front() !== (o_cfg_rdata_ff | o_err_report_ff)) begin
        failures++;
        $display("unexpected at %0t: got %h", $time, o_cfg_rdata_ff | o_err_report_ff);
      end
    end
  end
  task op(input logic w, r, input logic [11:0] a, input logic [31:0] v, x, e);
    if (r || e) q.push_back(e);
    @(posedge i_clk) #1 {i_cfg_wr, i_cfg_rd, i_cfg_addr, i_cfg_wdata, i_err_detect} = {w, r, a, v, x};
    @(posedge i_clk) #1 {i_cfg_wr, i_cfg_rd, i_err_detect} = 0;
  endtask
  task finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    d = $urandom(32'h3251);
    #126 i_resetn = 1;
    s = 0;
    op(0, 1, 12'h108, 0, 0, 0);
    repeat (16) begin
      d = $urandom;
      op(1, 0, 12'h108, d, 0, 0);
      m = d & 32'h001f3031;
      op(0, 1, 12'h108, 0, 0, m);
      checks++;
      if (o_uncorrectable_error_mask_ff !== m) begin
        failures++;
        $display("unexpected at %0t: mask copy %h", $time, o_uncorrectable_error_mask_ff);
      end
      d = $urandom;
      m = d & ~m & 32'h001f3030;
      n += m != 0;
      s |= m;
      op(0, 0, 0, 0, d, m);
      op(0, 1, 12'h104, 0, 0, s);
      d = $urandom;
      op(1, 0, 12'h104, d, 0, 0);
      s &= ~d;
    end
    op(0, 1, 12'h200, 0, 0, 0);
    #2 checks++;
    if (cnt !== n || q.size() != 0) begin
      failures++;
      $display("unexpected at %0t: report count", $time);
    end
    $display("mask test done");
    finish_test;
  end
endmodule // testbench
`default_nettype wire

/* test/uem_root.sv */
`timescale 1ns/1ps
`default_nettype none
module uem_root (
  input wire i_clk,
  input wire i_valid,
  output logic [7:0] o_count_ff = 8'h00
);
  // Counts arrivals only; class and severity are judged elsewhere
  always @(posedge i_clk) begin
    if (i_valid) o_count_ff <= o_count_ff + 8'h01;
  end
endmodule // uem_root
`default_nettype wire

/* test/uem_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module uem_sva (
  input wire i_clk,
  input wire i_resetn,
  input wire i_cfg_wr,
  input wire [31:0] i_err_detect,
  input wire [31:0] o_uncorrectable_error_mask_ff,
  input wire [31:0] o_uncorrectable_error_status_ff,
  input wire [31:0] o_err_report_ff,
  input wire o_err_report_valid_ff
);
  wire [31:0] m = o_uncorrectable_error_mask_ff;
  wire [31:0] s = o_uncorrectable_error_status_ff;
  wire [31:0] r = o_err_report_ff;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_rsvd_zero: assert property ((m & 32'hffe0cfce) == 0) else $error("mask rsvd");
  a_stat_rsvd: assert property ((s & 32'hffe0cfcf) == 0) else $error("stat rsvd");
  a_rep_masked: assert property ((r & m) == 0) else $error("masked");
  a_rep_exact: assert property (r == ($past(i_err_detect) & 32'h001f3030 & ~m)) else $error("report");
  a_rep_valid: assert property (o_err_report_valid_ff == (r != 0)) else $error("valid");
  a_stat_new: assert property ((s & ~$past(s) & ~$past(r)) == 0) else $error("logged");
  a_stat_set: assert property (r != 0 |-> ##1 (s & $past(r)) == $past(r)) else $error("unset");
  a_mask_hold: assert property (!$past(i_cfg_wr, 2) |-> $stable(m)) else $error("mask moved");
endmodule // uem_sva
bind uem_aer_mask uem_sva i_sva (.*);
`default_nettype wire
